// ===== rtl/macu_arg_bank.v
`timescale 1ns/1ps
`include "macu_defines.vh"

module macu_arg_bank (
  input wire clk,
  input wire rstn,
  input wire wr_en,
  input wire [`MACU_SLOT_W-1:0] wr_slot,
  input wire [`MACU_BYTE_W-1:0] wr_data,
  output wire [`MACU_BANK_W-1:0] args
);

  reg [`MACU_BYTE_W-1:0] mem [0:`MACU_SLOTS-1];
  integer i;

  // Each byte holds until rewritten or reset. [RQ13]
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < `MACU_SLOTS; i = i + 1) begin
        mem[i] <= `MACU_ARG_RST;
      end
    end else if (wr_en) begin
      mem[wr_slot] <= wr_data;
    end
  end

  // Bytes are packed low slot first, so each operand sits in its own field.
  genvar g;
  generate
    for (g = 0; g < `MACU_SLOTS; g = g + 1) begin : pack
      assign args[g*`MACU_BYTE_W +: `MACU_BYTE_W] = mem[g];
    end
  endgenerate

endmodule // macu_arg_bank

// ===== rtl/macu_defines.vh
`ifndef MACU_DEFINES_VH
`define MACU_DEFINES_VH

// Operand, result, byte and address widths.
`define MACU_MULT_W 16
`define MACU_SUM_W 32
`define MACU_BYTE_W 8
`define MACU_ADDR_W 8

// Byte addresses of the argument registers (write side).
`define MACU_OFS_ACC0 8'hc4
`define MACU_OFS_ACC1 8'hc5
`define MACU_OFS_ACC2 8'hc6
`define MACU_OFS_ACC3 8'hc7
`define MACU_OFS_MLR_LO 8'he6
`define MACU_OFS_MLR_HI 8'he7
`define MACU_OFS_MCD_LO 8'hee
`define MACU_OFS_MCD_HI 8'hef

// Byte addresses of the result registers (read side).
`define MACU_OFS_RES0 8'hea
`define MACU_OFS_RES1 8'heb
`define MACU_OFS_RES2 8'hec
`define MACU_OFS_RES3 8'hef

// Slot numbers inside the argument bank.
`define MACU_SLOT_W 3
`define MACU_SLOT_MLR_LO 3'h0
`define MACU_SLOT_MLR_HI 3'h1
`define MACU_SLOT_MCD_LO 3'h2
`define MACU_SLOT_MCD_HI 3'h3
`define MACU_SLOT_ACC0 3'h4
`define MACU_SLOT_ACC1 3'h5
`define MACU_SLOT_ACC2 3'h6
`define MACU_SLOT_ACC3 3'h7
`define MACU_SLOTS 8

// Field positions in the flat argument vector.
`define MACU_FLD_MLR_LSB 0
`define MACU_FLD_MCD_LSB 16
`define MACU_FLD_ACC_LSB 32
`define MACU_BANK_W 64

// Reset values.
`define MACU_ARG_RST 8'h00
`define MACU_RDATA_RST 8'h00

`endif

// ===== rtl/macu_top.v
// Function
// RQ1: Result is multiplier times multiplicand plus addend.
// RQ2: Multiplier, multiplicand 16 bits; addend, result 32.
// RQ3: Processor writes every argument one byte each.
// RQ4: Result readable at once, no start or busy.
// RQ5: Argument byte registers are write-only.
// RQ6: Result byte registers read-only; writes ignored.
// RQ7: Multiplier low byte E6, high byte E7.
// RQ8: Multiplicand low byte EE, high byte EF.
// RQ9: Addend bytes C4 through C7, low first.
// RQ10: Result bytes 0..2 read at EA..EC.
// RQ11: Result byte 3 read at EF.
// RQ12: Unsigned operands; carry above bit 31 dropped.
// RQ13: Arguments hold until rewritten; reset to zero.
`timescale 1ns/1ps
`include "macu_defines.vh"

module macu_top (
  input wire CLK,
  input wire RSTN,
  input wire [`MACU_ADDR_W-1:0] REG_ADDR,
  input wire REG_WE,
  input wire [`MACU_BYTE_W-1:0] REG_WDATA,
  input wire REG_RE,
  output reg [`MACU_BYTE_W-1:0] REG_RDATA,
  output reg REG_RHIT
);

  // Address EF is shared: a write loads the multiplicand high byte,
  // while a read returns the top result byte. The two sides never meet,
  // so software cannot read back what it wrote there.

  // True for the eight argument byte addresses; any other write is dropped.
  function wr_hit;
    input [`MACU_ADDR_W-1:0] addr;
    begin
      case (addr)
        `MACU_OFS_MLR_LO: begin
          wr_hit = 1'b1; // [RQ7]
        end

        `MACU_OFS_MLR_HI: begin
          wr_hit = 1'b1; // [RQ7]
        end

        `MACU_OFS_MCD_LO: begin
          wr_hit = 1'b1; // [RQ8]
        end

        `MACU_OFS_MCD_HI: begin
          wr_hit = 1'b1; // [RQ8] [RQ11]
        end

        `MACU_OFS_ACC0: begin
          wr_hit = 1'b1; // [RQ9]
        end

        `MACU_OFS_ACC1: begin
          wr_hit = 1'b1; // [RQ9]
        end

        `MACU_OFS_ACC2: begin
          wr_hit = 1'b1; // [RQ9]
        end

        `MACU_OFS_ACC3: begin
          wr_hit = 1'b1; // [RQ9]
        end

        default: begin
          wr_hit = 1'b0; // [RQ6]
        end
      endcase
    end
  endfunction

  // Slot of the argument bank that a write address lands in.
  function [`MACU_SLOT_W-1:0] wr_slot;
    input [`MACU_ADDR_W-1:0] addr;
    begin
      case (addr)
        `MACU_OFS_MLR_LO: begin
          wr_slot = `MACU_SLOT_MLR_LO; // [RQ7]
        end

        `MACU_OFS_MLR_HI: begin
          wr_slot = `MACU_SLOT_MLR_HI; // [RQ7]
        end

        `MACU_OFS_MCD_LO: begin
          wr_slot = `MACU_SLOT_MCD_LO; // [RQ8]
        end

        `MACU_OFS_MCD_HI: begin
          wr_slot = `MACU_SLOT_MCD_HI; // [RQ8] [RQ11]
        end

        `MACU_OFS_ACC0: begin
          wr_slot = `MACU_SLOT_ACC0; // [RQ9]
        end

        `MACU_OFS_ACC1: begin
          wr_slot = `MACU_SLOT_ACC1; // [RQ9]
        end

        `MACU_OFS_ACC2: begin
          wr_slot = `MACU_SLOT_ACC2; // [RQ9]
        end

        `MACU_OFS_ACC3: begin
          wr_slot = `MACU_SLOT_ACC3; // [RQ9]
        end

        default: begin
          wr_slot = `MACU_SLOT_MLR_LO;
        end
      endcase
    end
  endfunction

  // True for the four result addresses; argument addresses other than EF give no hit. [RQ5]
  function rd_hit;
    input [`MACU_ADDR_W-1:0] addr;
    begin
      case (addr)
        `MACU_OFS_RES0: begin
          rd_hit = 1'b1; // [RQ10]
        end

        `MACU_OFS_RES1: begin
          rd_hit = 1'b1; // [RQ10]
        end

        `MACU_OFS_RES2: begin
          rd_hit = 1'b1; // [RQ10]
        end

        `MACU_OFS_RES3: begin
          rd_hit = 1'b1; // [RQ11]
        end

        default: begin
          rd_hit = 1'b0; // [RQ5]
        end
      endcase
    end
  endfunction

  // Result byte for a read address; zero where no result register sits.
  function [`MACU_BYTE_W-1:0] rd_byte;
    input [`MACU_ADDR_W-1:0] addr;
    input [`MACU_SUM_W-1:0] res;
    begin
      case (addr)
        `MACU_OFS_RES0: begin
          rd_byte = res[7:0]; // [RQ10]
        end

        `MACU_OFS_RES1: begin
          rd_byte = res[15:8]; // [RQ10]
        end

        `MACU_OFS_RES2: begin
          rd_byte = res[23:16]; // [RQ10]
        end

        `MACU_OFS_RES3: begin
          rd_byte = res[31:24]; // [RQ11]
        end

        default: begin
          rd_byte = `MACU_RDATA_RST; // [RQ5]
        end
      endcase
    end
  endfunction

  // One byte of the flat argument vector by slot number.
  function [`MACU_BYTE_W-1:0] bank_byte;
    input [`MACU_BANK_W-1:0] bank;
    input [`MACU_SLOT_W-1:0] slot;
    begin
      bank_byte = bank[slot*`MACU_BYTE_W +: `MACU_BYTE_W];
    end
  endfunction

  // The sum is cut to 32 bits; a carry out of bit 31 is lost. [RQ12]
  function [`MACU_SUM_W-1:0] add_trunc;
    input [`MACU_SUM_W-1:0] a;
    input [`MACU_SUM_W-1:0] b;
    reg [`MACU_SUM_W:0] full;
    begin
      full = {1'b0, a} + {1'b0, b};
      add_trunc = full[`MACU_SUM_W-1:0];
    end
  endfunction

  // Shift-and-add keeps the product unsigned; 16 by 16 bits never exceeds 32. [RQ12]
  function [`MACU_SUM_W-1:0] umul;
    input [`MACU_MULT_W-1:0] a;
    input [`MACU_MULT_W-1:0] b;
    reg [`MACU_SUM_W-1:0] acc;
    reg [`MACU_SUM_W-1:0] part;
    integer k;
    begin
      acc = {`MACU_SUM_W{1'b0}};
      part = {`MACU_SUM_W{1'b0}};
      for (k = 0; k < `MACU_MULT_W; k = k + 1) begin
        part = {{(`MACU_SUM_W-`MACU_MULT_W){1'b0}}, a} << k;
        if (b[k]) begin
          acc = add_trunc(acc, part);
        end
      end
      umul = acc;
    end
  endfunction

  wire arg_hit;
  wire [`MACU_SLOT_W-1:0] arg_slot;
  wire arg_write;
  wire [`MACU_BANK_W-1:0] args;
  wire [`MACU_BYTE_W-1:0] multiplier_low_byte;
  wire [`MACU_BYTE_W-1:0] multiplier_high_byte;
  wire [`MACU_BYTE_W-1:0] multiplicand_low_byte;
  wire [`MACU_BYTE_W-1:0] multiplicand_high_byte;
  wire [`MACU_BYTE_W-1:0] accumulator_byte0;
  wire [`MACU_BYTE_W-1:0] accumulator_byte1;
  wire [`MACU_BYTE_W-1:0] accumulator_byte2;
  wire [`MACU_BYTE_W-1:0] accumulator_byte3;
  wire [`MACU_MULT_W-1:0] multiplier_operand;
  wire [`MACU_MULT_W-1:0] multiplicand_operand;
  wire [`MACU_SUM_W-1:0] addend_operand;
  wire [`MACU_SUM_W-1:0] product;
  wire [`MACU_SUM_W-1:0] product_sum;
  wire res_hit;
  wire [`MACU_BYTE_W-1:0] res_byte;
  reg [`MACU_BYTE_W-1:0] next_rdata;
  reg next_rhit;

  // Writes to result-only addresses miss wr_hit, so arg_write stays low and they are dropped. [RQ6]
  assign arg_hit = wr_hit(REG_ADDR);
  assign arg_slot = wr_slot(REG_ADDR);
  assign arg_write = REG_WE & arg_hit; // [RQ3]

  // The bank has no read port toward the bus, which keeps the arguments write-only. [RQ5]
  macu_arg_bank u_bank (
    .clk(CLK),
    .rstn(RSTN),
    .wr_en(arg_write),
    .wr_slot(arg_slot),
    .wr_data(REG_WDATA),
    .args(args)
  );

  // Byte slots named after the registers that load them.
  assign multiplier_low_byte = bank_byte(args, `MACU_SLOT_MLR_LO); // [RQ7]
  assign multiplier_high_byte = bank_byte(args, `MACU_SLOT_MLR_HI); // [RQ7]
  assign multiplicand_low_byte = bank_byte(args, `MACU_SLOT_MCD_LO); // [RQ8]
  assign multiplicand_high_byte = bank_byte(args, `MACU_SLOT_MCD_HI); // [RQ8]
  assign accumulator_byte0 = bank_byte(args, `MACU_SLOT_ACC0); // [RQ9]
  assign accumulator_byte1 = bank_byte(args, `MACU_SLOT_ACC1); // [RQ9]
  assign accumulator_byte2 = bank_byte(args, `MACU_SLOT_ACC2); // [RQ9]
  assign accumulator_byte3 = bank_byte(args, `MACU_SLOT_ACC3); // [RQ9]

  assign multiplier_operand = {multiplier_high_byte, multiplier_low_byte}; // [RQ2] [RQ7]
  assign multiplicand_operand = {multiplicand_high_byte, multiplicand_low_byte}; // [RQ2] [RQ8]
  assign addend_operand = {accumulator_byte3, accumulator_byte2, accumulator_byte1, accumulator_byte0}; // [RQ2] [RQ9]

  // Purely combinational, so the sum follows the bank with no start or busy state.
  // Only the addition can carry out, and that carry is dropped on purpose.
  assign product = umul(multiplier_operand, multiplicand_operand); // [RQ1] [RQ12]
  assign product_sum = add_trunc(product, addend_operand); // [RQ1] [RQ4] [RQ12]

  assign res_hit = rd_hit(REG_ADDR);
  assign res_byte = rd_byte(REG_ADDR, product_sum);

  // Read data holds between reads so a slow poll still sees the last byte.
  always @* begin
    next_rdata = REG_RDATA;
    if (REG_RE) begin
      next_rdata = res_byte; // [RQ4] [RQ5]
    end
  end

  always @* begin
    next_rhit = 1'b0;
    if (REG_RE) begin
      next_rhit = res_hit; // [RQ10] [RQ11]
    end
  end

  // Read data is registered so the bus sees a clean flop; it lands one edge after the strobe.
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= `MACU_RDATA_RST;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RHIT <= 1'b0;
    end else begin
      REG_RHIT <= next_rhit;
    end
  end

endmodule // macu_top

// ===== tb/macu_cpu.sv
`timescale 1ns/1ps
module macu_cpu (
  input wire clk,
  input wire [7:0] rdata,
  input wire rhit,
  output reg [7:0] addr = 8'h00,
  output reg we = 1'b0,
  output reg [7:0] wdata = 8'h00,
  output reg re = 1'b0
);
  // One byte access; read data and hit are taken at the edge after the one that takes the strobe.
  task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q, output h);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      we <= w;
      re <= !w;
      @(posedge clk);
      // Idle address and data lines show inverted values and both strobes drop low, so a stale byte cannot pass.
      addr <= ~a;
      wdata <= ~d;
      we <= 1'b0;
      re <= 1'b0;
      @(posedge clk);
      q = rdata;
      h = rhit;
    end
  endtask
endmodule // macu_cpu

// ===== tb/macu_properties.sv
`timescale 1ns/1ps
module macu_props (
  input wire CLK,
  input wire RSTN,
  input wire [7:0] REG_ADDR,
  input wire REG_WE,
  input wire REG_RE,
  input wire [7:0] REG_RDATA,
  input wire REG_RHIT
);
  wire rr = REG_RE && (REG_ADDR == 8'hea || REG_ADDR == 8'heb || REG_ADDR == 8'hec || REG_ADDR == 8'hef);
  wire ar = REG_RE && (REG_ADDR[7:2] == 6'h31 || REG_ADDR == 8'he6 || REG_ADDR == 8'hee);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  property p_hit; rr |=> REG_RHIT; endproperty
  a_hit: assert property (p_hit) else $error("no hit");
  property p_mis; !rr |=> !REG_RHIT; endproperty
  a_mis: assert property (p_mis) else $error("stray hit");
  property p_src; REG_RHIT |-> $past(rr); endproperty
  a_src: assert property (p_src) else $error("hit cause");
  property p_hold; !REG_RE |=> $stable(REG_RDATA); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_wo; ar |=> REG_RDATA == 8'h00; endproperty
  a_wo: assert property (p_wo) else $error("arg read");
  property p_ef; REG_WE && !REG_RE && REG_ADDR == 8'hef |=> !REG_RHIT; endproperty
  a_ef: assert property (p_ef) else $error("ef write");
  property p_pul; rr ##1 !REG_RE |=> !REG_RHIT; endproperty
  a_pul: assert property (p_pul) else $error("long hit");
  property p_efr; REG_RE && REG_ADDR == 8'hef |=> REG_RHIT; endproperty
  a_efr: assert property (p_efr) else $error("ef read");
  cover property (rr);
  cover property (ar);
  cover property (REG_WE && REG_ADDR == 8'hef);
endmodule // macu_props

// ===== tb/macu_tb.sv
`timescale 1ns/1ps
module macu_tb;
  reg CLK = 1'b0;
  reg RSTN = 1'b0;
  wire [7:0] ad, wd, rd;
  wire we, re, hit;
  integer fails = 0;
  integer compares = 0;
  reg [7:0] q;
  reg h;
  initial begin
    forever #4 CLK = ~CLK;
  end
  macu_top i_dut (.CLK(CLK), .RSTN(RSTN), .REG_ADDR(ad), .REG_WE(we), .REG_WDATA(wd), .REG_RE(re),
    .REG_RDATA(rd), .REG_RHIT(hit));
  macu_cpu i_cpu (.clk(CLK), .rdata(rd), .rhit(hit), .addr(ad), .we(we), .wdata(wd), .re(re));
  task chk(input string n, input [7:0] e, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("BAD %s exp %h got %h", n, e, g);
      end
    end
  endtask
  task close_out;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task load(input [63:0] v);
    reg [63:0] a;
    integer i;
    begin
      a = 64'hc7c6c5c4efeee7e6;
      for (i = 0; i < 8; i = i + 1) begin
        i_cpu.xfer(1'b1, a[8*i +: 8], v[8*i +: 8], q, h);
      end
    end
  endtask
  task res(input [31:0] e);
    reg [31:0] a;
    integer i;
    begin
      a = 32'hefecebea;
      for (i = 0; i < 4; i = i + 1) begin
        i_cpu.xfer(1'b0, a[8*i +: 8], 8'h00, q, h);
        chk("result", e[8*i +: 8], q);
        chk("hit", 8'h01, {7'h00, h});
      end
      $display("test result %h done", e);
    end
  endtask
  initial begin
    repeat (10) @(posedge CLK);
    RSTN <= 1'b1;
    res(32'h0);
    load(64'hffffffff_ffff_ffff);
    res(32'hfffe0000);
    load(64'h11223344_5678_1234);
    res(32'h1234 * 32'h5678 + 32'h11223344);
    i_cpu.xfer(1'b1, 8'hea, 8'hff, q, h);
    i_cpu.xfer(1'b1, 8'hec, 8'hff, q, h);
    res(32'h1234 * 32'h5678 + 32'h11223344);
    i_cpu.xfer(1'b0, 8'he6, 8'h00, q, h);
    chk("arg", 8'h00, q);
    chk("arg hit", 8'h00, {7'h00, h});
    $display("test write-only done");
    RSTN <= 1'b0;
    repeat (10) @(posedge CLK);
    RSTN <= 1'b1;
    res(32'h0);
    close_out;
  end
  initial begin
    repeat (3000) @(posedge CLK);
    fails = fails + 1;
    close_out;
  end
endmodule // macu_tb
bind macu_top macu_props i_props (.CLK(CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WE(REG_WE), .REG_RE(REG_RE),
  .REG_RDATA(REG_RDATA), .REG_RHIT(REG_RHIT));
